// ---- src/itsh_regs.vh ----
// Register offsets, field positions and reset values of the interval timer and shifter.
`ifndef ITSH_REGS_VH
`define ITSH_REGS_VH

`define ITSH_RS_W 4
`define ITSH_REG_T2_LOW 4'h8
`define ITSH_REG_T2_HIGH 4'h9
`define ITSH_REG_SHIFT 4'hA
`define ITSH_REG_AUX 4'hB
`define ITSH_REG_FLAG 4'hD
`define ITSH_REG_ENABLE 4'hE

`define ITSH_AUX_PULSE_BIT 5
`define ITSH_AUX_SR_HI 4
`define ITSH_AUX_SR_LO 2
`define ITSH_FLAG_SR_BIT 2
`define ITSH_FLAG_T2_BIT 5
`define ITSH_FLAG_ANY_BIT 7
`define ITSH_ENABLE_SET_BIT 7

`define ITSH_SR_OFF 3'h0
`define ITSH_SR_IN_T2 3'h1
`define ITSH_SR_IN_CLK 3'h2
`define ITSH_SR_IN_EXT 3'h3
`define ITSH_SR_OUT_FREE 3'h4
`define ITSH_SR_OUT_T2 3'h5
`define ITSH_SR_OUT_CLK 3'h6
`define ITSH_SR_OUT_EXT 3'h7

`define ITSH_BITS_PER_FRAME 3'h7
`define ITSH_RST_BYTE 8'h00
`define ITSH_RST_WORD 16'h0000

`endif

// ---- src/itsh_shift_unit.v ----
// Eight-bit MSB-first shift engine with bit counter and shift clock generation.
`timescale 1ns/1ps
`default_nettype none
`include "itsh_regs.vh"

module itsh_shift_unit (
  input wire core_clk,
  input wire rst_n,
  input wire [2:0] mode,
  input wire wr_stb,
  input wire rd_stb,
  input wire [7:0] wdata,
  input wire int_tick,
  input wire ext_fall,
  input wire data_in,
  output reg [7:0] sr_q_ff,
  output reg data_out_ff,
  output reg clk_out_ff,
  output reg done_ff
);

  reg active_ff;
  reg [2:0] cnt_ff;
  wire is_out = mode[2];
  wire is_ext = (mode[1:0] == 2'b11);
  wire is_free = (mode == `ITSH_SR_OUT_FREE);
  wire enabled = (mode != `ITSH_SR_OFF);
  // Shift-out starts on a write; shift-in on a read or a write.
  wire start = enabled & (wr_stb | (~is_out & rd_stb));
  wire edge_ev = is_ext ? ext_fall : int_tick;
  // Only an external edge may coincide with the start and shift at once; an internal
  // tick in the start cycle is skipped, so an internally paced frame stays at eight bits.
  wire shift_ev = edge_ev & (is_ext ? (active_ff | start) : (active_ff & ~start));
  // A coinciding external edge shifts the freshly stored byte at once.
  wire [7:0] base = wr_stb ? wdata : sr_q_ff;
  wire fill = is_out ? (is_free ? base[7] : 1'b0) : data_in;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_ff <= 1'b0;
      cnt_ff <= 3'h0;
      sr_q_ff <= `ITSH_RST_BYTE;
      data_out_ff <= 1'b1;
      clk_out_ff <= 1'b1;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      clk_out_ff <= ~(shift_ev & ~is_ext);
      if (wr_stb)
        sr_q_ff <= wdata;
      if (start) begin
        // A new byte restarts the bit count; the frame ends after eight counted shifts, except in free-running mode.
        active_ff <= 1'b1;
        cnt_ff <= 3'h0;
      end
      if (!enabled)
        active_ff <= 1'b0;
      else if (shift_ev) begin
        sr_q_ff <= {base[6:0], fill};
        if (is_out)
          data_out_ff <= base[7];
        if (!start) begin
          cnt_ff <= cnt_ff + 3'h1;
          if (cnt_ff == `ITSH_BITS_PER_FRAME && !is_free) begin
            active_ff <= 1'b0;
            done_ff <= 1'b1;
          end
        end
      end
    end
  end

endmodule // itsh_shift_unit
`default_nettype wire

// ---- src/itsh_timer_shifter.v ----
// Second interval timer, pulse counter, shift register and flag summary of the adapter.
`timescale 1ns/1ps
`default_nettype none
`include "itsh_regs.vh"

module itsh_timer_shifter #(
  parameter CNT_W = 16
) (
  input wire core_clk,
  input wire rst_n,
  input wire bus_sel,
  input wire bus_rw,
  input wire [`ITSH_RS_W-1:0] bus_rs,
  input wire [7:0] bus_wdata,
  output reg [7:0] bus_rdata_ff,
  output wire irq_n,
  input wire [6:0] other_flags,
  input wire pulse_count_input,
  input wire external_shift_clock_in,
  output wire external_shift_clock_out,
  output wire external_shift_clock_oe,
  input wire shift_data_line_in,
  output wire shift_data_line_out,
  output wire shift_data_line_oe
);

  reg [CNT_W-1:0] t2_cnt_ff;
  reg [CNT_W-1:0] nxt_t2_cnt;
  reg [7:0] t2_latch_ff;
  reg t2_armed_ff;
  reg t2_flag_ff;
  reg sr_flag_ff;
  reg [6:0] ier_ff;
  reg [7:0] acr_ff;
  reg pulse_prev_ff;
  reg ext_clk_prev_ff;
  reg phase_div_ff;
  reg [7:0] nxt_rdata;

  wire [7:0] sr_q;
  wire sr_done;
  wire shift_clk_raw;

  // Bus strobes: one access per cycle in which bus_sel is high.
  wire bus_wr = bus_sel & ~bus_rw;
  wire bus_rd = bus_sel & bus_rw;
  wire wr_t2_low = bus_wr & (bus_rs == `ITSH_REG_T2_LOW);
  wire wr_t2_high = bus_wr & (bus_rs == `ITSH_REG_T2_HIGH);
  wire rd_t2_low = bus_rd & (bus_rs == `ITSH_REG_T2_LOW);
  wire wr_sr = bus_wr & (bus_rs == `ITSH_REG_SHIFT);
  wire rd_sr = bus_rd & (bus_rs == `ITSH_REG_SHIFT);
  wire wr_acr = bus_wr & (bus_rs == `ITSH_REG_AUX);
  wire wr_ifr = bus_wr & (bus_rs == `ITSH_REG_FLAG);
  wire wr_ier = bus_wr & (bus_rs == `ITSH_REG_ENABLE);

  wire [2:0] sr_mode = acr_ff[`ITSH_AUX_SR_HI:`ITSH_AUX_SR_LO];
  wire pulse_mode = acr_ff[`ITSH_AUX_PULSE_BIT];

  // The timer paces the shifter in modes 001, 100 and 101.
  wire sr_uses_t2 = (sr_mode == `ITSH_SR_IN_T2) |
                    (sr_mode == `ITSH_SR_OUT_FREE) |
                    (sr_mode == `ITSH_SR_OUT_T2);
  wire sr_uses_clk = (sr_mode == `ITSH_SR_IN_CLK) |
                     (sr_mode == `ITSH_SR_OUT_CLK);

  // Inputs are synchronous, so a registered copy is enough for edge detection.
  wire pulse_fall = pulse_prev_ff & ~pulse_count_input;
  wire ext_fall = ext_clk_prev_ff & ~external_shift_clock_in;

  wire t2_dec = pulse_mode ? pulse_fall : 1'b1;
  wire t2_zero = (t2_cnt_ff == {CNT_W{1'b0}});
  wire low_zero = (t2_cnt_ff[7:0] == 8'h00);

  // Wrap past zero marks the timeout in both counting modes.
  wire t2_wrap = ~sr_uses_t2 & ~wr_t2_high & t2_dec & t2_zero;
  wire t2_timeout = t2_wrap & t2_armed_ff;
  wire t2_shift_tick = sr_uses_t2 & ~wr_t2_high & low_zero;
  wire int_tick = sr_uses_t2 ? t2_shift_tick : (sr_uses_clk & phase_div_ff);

  wire [6:0] flags = {other_flags[6], t2_flag_ff, other_flags[4:3],
                      sr_flag_ff, other_flags[1:0]};
  wire any_irq = |(flags & ier_ff);

  assign irq_n = ~any_irq;

  always @* begin
    nxt_t2_cnt = t2_cnt_ff;
    if (wr_t2_high)
      nxt_t2_cnt = {bus_wdata, t2_latch_ff};
    else if (sr_uses_t2) begin
      // Only the low byte runs when the timer paces the shifter.
      if (low_zero)
        nxt_t2_cnt[7:0] = t2_latch_ff;
      else
        nxt_t2_cnt[7:0] = t2_cnt_ff[7:0] - 8'h01;
    end else if (t2_dec)
      nxt_t2_cnt = t2_cnt_ff - {{(CNT_W-1){1'b0}}, 1'b1};
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      t2_cnt_ff <= {CNT_W{1'b0}};
      t2_latch_ff <= `ITSH_RST_BYTE;
      t2_armed_ff <= 1'b0;
    end else begin
      t2_cnt_ff <= nxt_t2_cnt;
      if (wr_t2_low)
        t2_latch_ff <= bus_wdata;
      // One-shot: a further timeout needs a new high write.
      if (wr_t2_high)
        t2_armed_ff <= 1'b1;
      else if (t2_timeout)
        t2_armed_ff <= 1'b0;
    end
  end

  // Set wins over clear so a timeout in the clearing cycle is kept.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      t2_flag_ff <= 1'b0;
    else if (t2_timeout)
      t2_flag_ff <= 1'b1;
    else if (rd_t2_low | wr_t2_high |
             (wr_ifr & bus_wdata[`ITSH_FLAG_T2_BIT]))
      t2_flag_ff <= 1'b0;
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      sr_flag_ff <= 1'b0;
    else if (sr_done)
      sr_flag_ff <= 1'b1;
    else if (wr_sr | rd_sr | (wr_ifr & bus_wdata[`ITSH_FLAG_SR_BIT]))
      sr_flag_ff <= 1'b0;
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ier_ff <= 7'h00;
      acr_ff <= `ITSH_RST_BYTE;
      pulse_prev_ff <= 1'b1;
      ext_clk_prev_ff <= 1'b1;
      phase_div_ff <= 1'b0;
    end else begin
      pulse_prev_ff <= pulse_count_input;
      ext_clk_prev_ff <= external_shift_clock_in;
      // Halving the rate gives the clock-paced shifter a visible clock.
      phase_div_ff <= ~phase_div_ff;
      if (wr_acr)
        acr_ff <= bus_wdata;
      if (wr_ier) begin
        if (bus_wdata[`ITSH_ENABLE_SET_BIT])
          ier_ff <= ier_ff | bus_wdata[6:0];
        else
          ier_ff <= ier_ff & ~bus_wdata[6:0];
      end
    end
  end

  always @* begin
    nxt_rdata = bus_rdata_ff;
    if (bus_rd) begin
      case (bus_rs)
        `ITSH_REG_T2_LOW: nxt_rdata = t2_cnt_ff[7:0];
        `ITSH_REG_T2_HIGH: nxt_rdata = t2_cnt_ff[15:8];
        `ITSH_REG_SHIFT: nxt_rdata = sr_q;
        `ITSH_REG_AUX: nxt_rdata = acr_ff;
        `ITSH_REG_FLAG: nxt_rdata = {any_irq, flags};
        `ITSH_REG_ENABLE: nxt_rdata = {1'b1, ier_ff};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      bus_rdata_ff <= `ITSH_RST_BYTE;
    else
      bus_rdata_ff <= nxt_rdata;
  end

  itsh_shift_unit u_shift (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .mode(sr_mode),
    .wr_stb(wr_sr),
    .rd_stb(rd_sr),
    .wdata(bus_wdata),
    .int_tick(int_tick),
    .ext_fall(ext_fall),
    .data_in(shift_data_line_in),
    .sr_q_ff(sr_q),
    .data_out_ff(shift_data_line_out),
    .clk_out_ff(shift_clk_raw),
    .done_ff(sr_done)
  );

  // The shift clock pin is driven only in internally paced modes.
  assign external_shift_clock_oe = (sr_mode != `ITSH_SR_OFF) & (sr_mode[1:0] != 2'b11);
  assign external_shift_clock_out = shift_clk_raw;
  assign shift_data_line_oe = sr_mode[2];

endmodule // itsh_timer_shifter
`default_nettype wire

// ---- verification/itsh_timer_shifter_properties.sv ----
// Concurrent checks on the ports of the interval timer and shifter.
`timescale 1ns/1ps
`default_nettype none
module itsh_props #(
  parameter CNT_W = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic bus_sel,
  input wire logic bus_rw,
  input wire logic [3:0] bus_rs,
  input wire logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata_ff,
  input wire logic irq_n,
  input wire logic [6:0] other_flags,
  input wire logic pulse_count_input,
  input wire logic external_shift_clock_in,
  input wire logic external_shift_clock_out,
  input wire logic external_shift_clock_oe,
  input wire logic shift_data_line_in,
  input wire logic shift_data_line_out,
  input wire logic shift_data_line_oe
);
  logic [6:0] en_ff;
  logic [7:0] lat_ff;
  logic [7:0] aux_ff;
  wire logic wr = bus_sel && !bus_rw;
  wire logic rd = bus_sel && bus_rw;
  // Timer checks only apply when the timer flag alone can drive the interrupt.
  wire logic t2only = en_ff == 7'h20;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_ff <= 7'h00;
      lat_ff <= 8'h00;
      aux_ff <= 8'h00;
    end else if (wr) begin
      if (bus_rs == 4'hE)
        en_ff <= bus_wdata[7] ? (en_ff | bus_wdata[6:0]) : (en_ff & ~bus_wdata[6:0]);
      if (bus_rs == 4'h8)
        lat_ff <= bus_wdata;
      if (bus_rs == 4'hB)
        aux_ff <= bus_wdata;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence t2_start3;
    wr && bus_rs == 4'h9 && bus_wdata == 8'h00 && lat_ff == 8'h03 && t2only && aux_ff == 8'h00;
  endsequence
  sequence t2_expire;
    irq_n [*4] ##1 !irq_n;
  endsequence
  a_timer_interval: assert property (t2_start3 |=> t2_expire)
    else $error("timer interrupt not at count plus one");
  a_low_read_clear: assert property (rd && bus_rs == 4'h8 && t2only && !irq_n |=> irq_n)
    else $error("low read left timer interrupt set");
  a_high_write_clear: assert property (wr && bus_rs == 4'h9 && t2only && !irq_n |=> irq_n)
    else $error("high write left timer interrupt set");
  a_irq_summary: assert property (rd && bus_rs == 4'hD
    |=> bus_rdata_ff[7] == !$past(irq_n))
    else $error("flag bit 7 differs from interrupt line");
  a_rdata_holds: assert property (!rd |=> $stable(bus_rdata_ff))
    else $error("read data changed without a read");
  a_clk_pulse_short: assert property ($fell(external_shift_clock_out) |=> external_shift_clock_out)
    else $error("shift clock low longer than one cycle");
  a_clk_idle_high: assert property (!external_shift_clock_oe |-> external_shift_clock_out)
    else $error("undriven shift clock output not idle");
  a_data_oe_mode: assert property (wr && bus_rs == 4'hB
    |=> shift_data_line_oe == $past(bus_wdata[4]))
    else $error("data line enable does not follow mode");
  a_clk_oe_mode: assert property (wr && bus_rs == 4'hB
    |=> external_shift_clock_oe == ($past(bus_wdata[4:2]) inside {3'h1, 3'h2, 3'h4, 3'h5, 3'h6}))
    else $error("shift clock enable does not follow mode");
endmodule // itsh_props
bind itsh_timer_shifter itsh_props #(.CNT_W(CNT_W)) chk_u (.core_clk, .rst_n, .bus_sel, .bus_rw,
  .bus_rs, .bus_wdata, .bus_rdata_ff, .irq_n, .other_flags, .pulse_count_input,
  .external_shift_clock_in, .external_shift_clock_out, .external_shift_clock_oe,
  .shift_data_line_in, .shift_data_line_out, .shift_data_line_oe);
`default_nettype wire

// ---- verification/itsh_far_model.sv ----
// Far-side model: pulse source, external shift clock and serial data partner.
`timescale 1ns/1ps
`default_nettype none
module itsh_far_model (
  input wire logic core_clk,
  input wire logic clk_pin,
  input wire logic data_pin,
  output logic pulse,
  output logic ext_clk,
  output logic data_drv
);
  int falls = 0;
  logic [7:0] got = 8'h00;
  initial begin
    pulse = 1'h1;
    ext_clk = 1'h1;
    data_drv = 1'h0;
  end
  // A released data line must not look like a held value, so it toggles.
  always @(posedge core_clk) data_drv <= ~data_drv;
  always @(negedge clk_pin) falls <= falls + 1;
  always @(posedge clk_pin) got <= {got[6:0], data_pin};
  // Edges follow the system clock and each phase lasts two cycles.
  task automatic run(input bit ext, input int n);
    repeat (n) begin
      repeat (2) @(posedge core_clk);
      #10;
      if (ext) ext_clk = 1'h0;
      else pulse = 1'h0;
      repeat (2) @(posedge core_clk);
      #10;
      if (ext) ext_clk = 1'h1;
      else pulse = 1'h1;
    end
  endtask
endmodule // itsh_far_model
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking testbench of the interval timer and shifter.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  logic sel = 1'h0;
  logic rw = 1'h0;
  logic [3:0] rs = 4'h0;
  logic [7:0] wd = 8'h00;
  logic [6:0] oth = 7'h00;
  logic [7:0] rd;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  wire logic [7:0] rdata;
  wire logic irq_n, ck_out, ck_oe, d_out, d_oe, pulse, ext_clk, data_drv;
  wire logic clk_pin = ck_oe ? ck_out : ext_clk;
  wire logic data_pin = d_oe ? d_out : data_drv;
  itsh_timer_shifter #(.CNT_W(16)) dut_u (.core_clk(core_clk), .rst_n(rst_n), .bus_sel(sel),
    .bus_rw(rw), .bus_rs(rs), .bus_wdata(wd), .bus_rdata_ff(rdata), .irq_n(irq_n),
    .other_flags(oth), .pulse_count_input(pulse), .external_shift_clock_in(clk_pin),
    .external_shift_clock_out(ck_out), .external_shift_clock_oe(ck_oe),
    .shift_data_line_in(data_pin), .shift_data_line_out(d_out), .shift_data_line_oe(d_oe));
  itsh_far_model far_u (.core_clk(core_clk), .clk_pin(clk_pin), .data_pin(data_pin),
    .pulse(pulse), .ext_clk(ext_clk), .data_drv(data_drv));
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic acc(input logic r, input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #10;
    sel = 1'h1;
    rw = r;
    rs = a;
    wd = d;
    @(posedge core_clk);
    #10;
    sel = 1'h0;
    rd = rdata;
  endtask
  task automatic wait_irq();
    n = 0;
    while (irq_n === 1'h1 && n < 400) begin
      @(posedge core_clk);
      #10;
      n++;
    end
  endtask
  task automatic settle();
    repeat (4) @(posedge core_clk);
    #10;
  endtask
  task automatic t_timer();
    acc(1'h0, 4'hE, 8'hA0);
    acc(1'h0, 4'hB, 8'h00);
    acc(1'h0, 4'h8, 8'h03);
    acc(1'h0, 4'h9, 8'h00);
    wait_irq();
    chk("timer delay", n[7:0], 8'h04);
    acc(1'h1, 4'hD, 8'h00);
    chk("flag register", rd, 8'hA0);
    acc(1'h1, 4'h9, 8'h00);
    chk("wrapped high", rd, 8'hFF);
    chk("irq after high read", {7'h00, irq_n}, 8'h00);
    acc(1'h1, 4'h8, 8'h00);
    chk("irq after low read", {7'h00, irq_n}, 8'h01);
    oth = 7'h01;
    acc(1'h0, 4'hE, 8'h81);
    acc(1'h1, 4'hD, 8'h00);
    chk("other flag summary", rd, 8'h81);
    chk("irq from other flag", {7'h00, irq_n}, 8'h00);
    acc(1'h0, 4'hE, 8'h01);
    oth = 7'h00;
    chk("irq after other disabled", {7'h00, irq_n}, 8'h01);
  endtask
  task automatic t_pulse();
    acc(1'h0, 4'hB, 8'h20);
    acc(1'h0, 4'h8, 8'h02);
    acc(1'h0, 4'h9, 8'h00);
    far_u.run(1'b0, 2);
    settle();
    chk("irq after two pulses", {7'h00, irq_n}, 8'h01);
    far_u.run(1'b0, 1);
    settle();
    chk("irq after third pulse", {7'h00, irq_n}, 8'h00);
    acc(1'h0, 4'h9, 8'h00);
    chk("irq after high write", {7'h00, irq_n}, 8'h01);
    acc(1'h0, 4'h8, 8'h07);
    acc(1'h1, 4'h8, 8'h00);
    chk("counter after low write", rd, 8'h02);
    acc(1'h1, 4'h9, 8'h00);
    chk("counter high after load", rd, 8'h00);
  endtask
  task automatic t_shift();
    // The pulse count stays loaded, so its enable goes off before mode changes.
    acc(1'h0, 4'hE, 8'h20);
    acc(1'h0, 4'hE, 8'h84);
    acc(1'h0, 4'hB, 8'h18);
    acc(1'h0, 4'hA, 8'hA5);
    wait_irq();
    settle();
    chk("shifted out byte", far_u.got, 8'hA5);
    chk("out clocks", far_u.falls[7:0], 8'h08);
    far_u.falls = 0;
    acc(1'h0, 4'hB, 8'h08);
    acc(1'h1, 4'hA, 8'h00);
    wait_irq();
    repeat (20) @(posedge core_clk);
    chk("in clocks", far_u.falls[7:0], 8'h08);
    acc(1'h0, 4'hB, 8'h1C);
    acc(1'h0, 4'hA, 8'h5A);
    chk("irq after shift write", {7'h00, irq_n}, 8'h01);
    far_u.run(1'b1, 7);
    settle();
    chk("irq after seven edges", {7'h00, irq_n}, 8'h01);
    far_u.run(1'b1, 1);
    settle();
    chk("irq after eighth edge", {7'h00, irq_n}, 8'h00);
    chk("external clocked byte", far_u.got, 8'h5A);
  endtask
  task automatic final_report();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    #10;
    rst_n = 1'h1;
    t_timer();
    t_pulse();
    t_shift();
    final_report();
  end
endmodule // tb_top
`default_nettype wire
